// *** core/rgbpwm_top.sv ***
// Purpose: three channel pwm cathode driver for an rgb led
// Assumes: serial bus host writes registers; pins synchronous to core_clk
// Notes:   register contents are lost at reset and reload power-on values
//
// Behaviour
// - written values are volatile; reset restores the power-on configuration.
// - refresh register sets the pwm period shared by all channels.
// - duty registers take 0 to 255, each step up to 254 one 256th of period; 255 is full on.
// - one shared phase counter, compared with three duty registers, drives red, green, blue on separate outputs.
// - red, green, blue duty registers sit at consecutive byte addresses.
// - refresh register has its own byte address apart from duties.
// - each further data byte in a write goes to the next address.
// - duty zero keeps channel off; maximum duty keeps it always on.
// - midscale duty gives roughly half-period pwm on that channel.
`timescale 1ns/1ns
`default_nettype none
module rgbpwm_top #(
  parameter logic [6:0] DEV_ADDR     = rgbpwm_pkg::CHIP_ADDR,
  parameter logic [7:0] RED_INIT     = rgbpwm_pkg::RED_INIT,
  parameter logic [7:0] GREEN_INIT   = rgbpwm_pkg::GREEN_INIT,
  parameter logic [7:0] BLUE_INIT    = rgbpwm_pkg::BLUE_INIT,
  parameter logic [7:0] REFRESH_INIT = rgbpwm_pkg::REFRESH_INIT,
  parameter int         BASE_CYCLES  = rgbpwm_pkg::BASE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  output logic      led_red_sink,
  output logic      led_green_sink,
  output logic      led_blue_sink
);
  import rgbpwm_pkg::*;

  localparam int NCH = 3;
  localparam logic [7:0]  CH_INIT [NCH] = '{RED_INIT, GREEN_INIT,
                                            BLUE_INIT};
  localparam logic [11:0] BASE_LAST     = 12'(BASE_CYCLES - 1);

  function automatic logic [1:0] chan_of(input logic [7:0] a);
    if (a == ADDR_RED)
      chan_of = CH_RED;
    else if (a == ADDR_GREEN)
      chan_of = CH_GREEN;
    else if (a == ADDR_BLUE)
      chan_of = CH_BLUE;
    else
      chan_of = CH_NONE;
  endfunction : chan_of

  logic [7:0]     duty_q [NCH];
  logic [7:0]     refresh_period_counter;
  logic [11:0]    base_cnt;
  logic [7:0]     step_cnt;
  logic [7:0]     phase;
  logic [NCH-1:0] sink;
  logic           wr_stb;
  logic [7:0]     reg_addr;
  logic [7:0]     wr_data;
  logic [7:0]     rd_data;

  wire logic [1:0] addr_ch     = chan_of(reg_addr);
  wire logic       refresh_hit = (reg_addr == ADDR_REFRESH);
  wire logic       refresh_wr  = wr_stb && refresh_hit;
  wire logic       base_tick   = (base_cnt == BASE_LAST);
  wire logic       step_tick   = base_tick &&
                                 (step_cnt == refresh_period_counter);

  // unmapped addresses read as zero and ignore writes
  assign rd_data = refresh_hit ? refresh_period_counter :
                   (addr_ch != CH_NONE) ? duty_q[addr_ch] : DUTY_OFF;

  assign led_red_sink   = sink[CH_RED];
  assign led_green_sink = sink[CH_GREEN];
  assign led_blue_sink  = sink[CH_BLUE];

  rgbpwm_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_slave (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .wr_stb   (wr_stb),
    .reg_addr (reg_addr),
    .wr_data  (wr_data),
    .rd_data  (rd_data)
  );

  // step length is (refresh+1) base ticks; period is 256 steps
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_period_counter <= REFRESH_INIT;
      base_cnt               <= 12'h000;
      step_cnt               <= 8'h00;
      phase                  <= 8'h00;
    end else begin
      if (refresh_wr)
        refresh_period_counter <= wr_data;
      base_cnt <= base_tick ? 12'h000 : base_cnt + 12'h001;
      if (step_tick)
        step_cnt <= 8'h00;
      else if (base_tick)
        step_cnt <= step_cnt + 8'h01;
      if (step_tick)
        phase <= phase + 8'h01;
    end
  end

  // a shorter refresh written mid-step just waits for step_cnt to wrap;
  // duty updates act at once, so one period may show a partial pulse
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    wire logic on = (duty_q[i] == DUTY_FULL) || (phase < duty_q[i]);
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        duty_q[i] <= CH_INIT[i];
        sink[i]   <= 1'b0;
      end else begin
        if (wr_stb && addr_ch == 2'(i))
          duty_q[i] <= wr_data;
        sink[i] <= on;
      end
    end
  end

  // checking aid: cycles between steps while refresh stays put
  logic [19:0] gap_cnt;
  logic        gap_valid;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt   <= 20'h00000;
      gap_valid <= 1'b0;
    end else begin
      gap_cnt   <= step_tick ? 20'h00000 : gap_cnt + 20'h00001;
      gap_valid <= step_tick ? 1'b1 : gap_valid && !refresh_wr;
    end
  end

  a_reset_defaults : assert property (
    @(posedge core_clk)
    $rose(rst_n) |-> duty_q[CH_RED] == RED_INIT &&
      duty_q[CH_GREEN] == GREEN_INIT && duty_q[CH_BLUE] == BLUE_INIT &&
      refresh_period_counter == REFRESH_INIT
  ) else $error("registers not at power-on values after reset");

  a_step_length : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (step_tick && gap_valid && !refresh_wr) |->
      gap_cnt == 20'((int'(refresh_period_counter) + 1) * BASE_CYCLES - 1)
  ) else $error("pwm step length does not follow refresh register");

  a_phase_wrap : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (step_tick && phase == DUTY_FULL) |=> phase == DUTY_OFF
  ) else $error("pwm period is not 256 steps");

  a_red_compare : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !$rose(rst_n) |-> led_red_sink ==
      ($past(phase) < $past(duty_q[CH_RED]) ||
       $past(duty_q[CH_RED]) == DUTY_FULL)
  ) else $error("red sink does not follow duty compare");

  a_blue_compare : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !$rose(rst_n) |-> led_blue_sink ==
      ($past(phase) < $past(duty_q[CH_BLUE]) ||
       $past(duty_q[CH_BLUE]) == DUTY_FULL)
  ) else $error("blue sink does not follow its own duty");

  a_zero_off : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $past(duty_q[CH_GREEN]) == DUTY_OFF |-> !led_green_sink
  ) else $error("green sinks with zero duty");

  a_full_on : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!$rose(rst_n) && $past(duty_q[CH_RED]) == DUTY_FULL) |-> led_red_sink
  ) else $error("red released with full duty");

  a_midscale : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!$rose(rst_n) && $past(duty_q[CH_GREEN]) == DUTY_MID) |->
      led_green_sink == !$past(phase[7])
  ) else $error("midscale duty is not half period");

  a_green_write : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (wr_stb && reg_addr == ADDR_GREEN) |=>
      duty_q[CH_GREEN] == $past(wr_data) && $stable(duty_q[CH_RED]) &&
      $stable(duty_q[CH_BLUE])
  ) else $error("green write landed on the wrong register");

  a_refresh_write : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (wr_stb && reg_addr == ADDR_REFRESH) |=>
      refresh_period_counter == $past(wr_data) && $stable(duty_q[CH_RED])
  ) else $error("refresh write not stored");

  a_unmapped_keep : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (wr_stb && chan_of(reg_addr) == CH_NONE && !refresh_hit) |=>
      $stable(duty_q[CH_RED]) && $stable(duty_q[CH_GREEN]) &&
      $stable(duty_q[CH_BLUE]) && $stable(refresh_period_counter)
  ) else $error("unmapped write changed a register");
endmodule : rgbpwm_top
`default_nettype wire

// *** inc/rgbpwm_pkg.sv ***
// Purpose: shared constants and types for the rgb pwm driver
// Assumes: 100 MHz core clock, serial bus slave reached by scl and sda
// Notes:   register byte addresses and power-on configuration live here
package rgbpwm_pkg;
  localparam int          CLK_NS       = 10;
  localparam int          PWM_HZ       = 100;
  localparam int          BASE_NS      = 160;
  localparam int          BASE_CYCLES  = (BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0]  CHIP_ADDR    = 7'h00;
  localparam logic [7:0]  ADDR_RED     = 8'hC0;
  localparam logic [7:0]  ADDR_GREEN   = 8'hC1;
  localparam logic [7:0]  ADDR_BLUE    = 8'hC2;
  localparam logic [7:0]  ADDR_REFRESH = 8'hC5;
  localparam logic [7:0]  DUTY_OFF     = 8'h00;
  localparam logic [7:0]  DUTY_MID     = 8'h80;
  localparam logic [7:0]  DUTY_FULL    = 8'hFF;
  localparam logic [7:0]  RED_INIT     = 8'h00;
  localparam logic [7:0]  GREEN_INIT   = 8'h00;
  localparam logic [7:0]  BLUE_INIT    = 8'h00;
  localparam logic [7:0]  REFRESH_INIT = 8'hF3;
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam logic [3:0]  BIT_FIRST    = 4'h1;
  localparam logic [1:0]  CH_RED       = 2'h0;
  localparam logic [1:0]  CH_GREEN     = 2'h1;
  localparam logic [1:0]  CH_BLUE      = 2'h2;
  localparam logic [1:0]  CH_NONE      = 2'h3;

  typedef enum logic [8:0] {
    ST_IDLE    = 9'h001,
    ST_DEV     = 9'h002,
    ST_DEV_ACK = 9'h004,
    ST_REG     = 9'h008,
    ST_REG_ACK = 9'h010,
    ST_WR      = 9'h020,
    ST_WR_ACK  = 9'h040,
    ST_RD      = 9'h080,
    ST_RD_ACK  = 9'h100
  } rgbpwm_i2c_st_t;
endpackage : rgbpwm_pkg

// *** core/rgbpwm_i2c_slave.sv ***
// Purpose: serial bus slave with auto-incrementing register pointer
// Assumes: scl and sda already synchronous to core_clk, slow vs. clock
// Notes:   sda is open drain; sda_oe high pulls the line low
`timescale 1ns/1ns
`default_nettype none
module rgbpwm_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = rgbpwm_pkg::CHIP_ADDR
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            wr_stb,
  output logic [7:0]      reg_addr,
  output logic [7:0]      wr_data,
  input  wire logic [7:0] rd_data
);
  import rgbpwm_pkg::*;

  rgbpwm_i2c_st_t state;
  logic           scl_q;
  logic           sda_q;
  logic           rw;
  logic           more;
  logic [3:0]     bit_cnt;
  logic [7:0]     shift;
  logic [7:0]     tx;

  wire logic       scl_rise   = scl_in & ~scl_q;
  wire logic       scl_fall   = ~scl_in & scl_q;
  wire logic       start_c    = scl_in & scl_q & sda_q & ~sda_in;
  wire logic       stop_c     = scl_in & scl_q & ~sda_q & sda_in;
  wire logic       byte_done  = (bit_cnt == BYTE_BITS);
  wire logic       addr_hit   = (shift[7:1] == DEV_ADDR);
  wire logic [7:0] next_shift = {shift[6:0], sda_in};
  wire logic [3:0] next_bit   = bit_cnt + 4'h1;
  wire logic       rx_state   = (state == ST_DEV) || (state == ST_REG) ||
                                (state == ST_WR);

  assign sda_out = 1'b0;

  // a start or stop anywhere re-frames the transfer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      rw       <= 1'b0;
      more     <= 1'b0;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      tx       <= 8'h00;
      sda_oe   <= 1'b0;
      wr_stb   <= 1'b0;
      reg_addr <= 8'h00;
      wr_data  <= 8'h00;
    end else begin
      scl_q  <= scl_in;
      sda_q  <= sda_in;
      wr_stb <= 1'b0;
      if (start_c) begin
        state   <= ST_DEV;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop_c) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (rx_state && scl_rise && !byte_done) begin
        shift   <= next_shift;
        bit_cnt <= next_bit;
      end else if (scl_fall) begin
        case (state)
          ST_DEV: if (byte_done) begin
            state  <= addr_hit ? ST_DEV_ACK : ST_IDLE;
            sda_oe <= addr_hit;
            rw     <= shift[0];
          end
          ST_DEV_ACK: begin
            state   <= rw ? ST_RD : ST_REG;
            sda_oe  <= rw & ~rd_data[7];
            tx      <= {rd_data[6:0], 1'b0};
            bit_cnt <= rw ? BIT_FIRST : 4'h0;
          end
          ST_REG: if (byte_done) begin
            state    <= ST_REG_ACK;
            reg_addr <= shift;
            sda_oe   <= 1'b1;
          end
          ST_WR: if (byte_done) begin
            state   <= ST_WR_ACK;
            wr_data <= shift;
            wr_stb  <= 1'b1;
            sda_oe  <= 1'b1;
          end
          ST_REG_ACK, ST_WR_ACK: begin
            state   <= ST_WR;
            sda_oe  <= 1'b0;
            bit_cnt <= 4'h0;
            if (state == ST_WR_ACK)
              reg_addr <= reg_addr + 8'h01;
          end
          ST_RD: if (byte_done) begin
            state    <= ST_RD_ACK;
            sda_oe   <= 1'b0;
            reg_addr <= reg_addr + 8'h01;
          end else begin
            sda_oe  <= ~tx[7];
            tx      <= {tx[6:0], 1'b0};
            bit_cnt <= next_bit;
          end
          ST_RD_ACK: begin
            state   <= more ? ST_RD : ST_IDLE;
            sda_oe  <= more & ~rd_data[7];
            tx      <= {rd_data[6:0], 1'b0};
            bit_cnt <= BIT_FIRST;
          end
          default: state <= ST_IDLE;
        endcase
      end else if (scl_rise && state == ST_RD_ACK) begin
        more <= ~sda_in;
      end
    end
  end

  a_pointer_step : assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (state == ST_WR_ACK && scl_fall && !start_c && !stop_c)
      |=> reg_addr == $past(reg_addr) + 8'h01 && state == ST_WR
  ) else $error("pointer did not advance after data byte");
endmodule : rgbpwm_i2c_slave
`default_nettype wire

// *** sim/rgbpwm_host.sv ***
// Purpose: bus host model that frames register writes and reads
// Assumes: sda wire resolved outside; pull-up gives high when released
// Notes:   scl stands high between frames, as a real host leaves it
`timescale 1ns/1ns
`default_nettype none
module rgbpwm_host #(
  parameter int HALF = 5
) (
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      host_oe
);
  initial begin
    scl     = 1'b1;
    host_oe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // sda falls while scl high opens the frame
  task automatic start_c();
    host_oe <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(2);
  endtask : start_c

  // data moves two cycles after scl fall, clear of the edge
  task automatic clk_bit(input logic drive_low, output logic seen);
    host_oe <= drive_low;
    tick(HALF);
    scl <= 1'b1;
    tick(2);
    seen = sda;
    tick(HALF - 2);
    scl <= 1'b0;
    tick(2);
  endtask : clk_bit

  // msb first, then a released ack slot
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(~b[i], s);
    end
    clk_bit(1'b0, s);
    ack = ~s;
  endtask : put

  task automatic get(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, s);
      b[i] = s;
    end
    clk_bit(~last, s);
  endtask : get

  // sda rises while scl high closes the frame
  task automatic stop_c();
    host_oe <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    host_oe <= 1'b0;
    tick(HALF);
  endtask : stop_c
endmodule : rgbpwm_host
`default_nettype wire

// *** sim/test_rgbpwm_top.sv ***
// Purpose: self-checking bench for the rgb pwm driver
// Assumes: short base tick and refresh 0 keep a period at 512 cycles
// Notes:   duty is judged by counting sink cycles over whole periods, over 64 cycles just after reset
`timescale 1ns/1ns
`default_nettype none
module test_rgbpwm_top;
  import rgbpwm_pkg::*;
  localparam int BASE = 2;
  logic core_clk;
  logic rst_n;
  logic scl;
  logic host_oe;
  logic sda_out;
  logic sda_oe;
  logic red;
  logic green;
  logic blue;
  logic sda;
  int   fails;
  int   tests_run;

  // open drain: low while host_oe, else sda_out while sda_oe, else the pull-up
  assign sda = !host_oe && (sda_oe ? sda_out : 1'b1);

  rgbpwm_top #(.BASE_CYCLES(BASE)) rgbpwm_top_i (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .led_red_sink(red),
    .led_green_sink(green), .led_blue_sink(blue));

  rgbpwm_host #(.HALF(5)) rgbpwm_host_i (
    .core_clk(core_clk), .sda(sda), .scl(scl), .host_oe(host_oe));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : do_reset

  task automatic send(input logic [7:0] b);
    logic ack;
    rgbpwm_host_i.put(b, ack);
    check({15'h0, ack}, 16'h1);
  endtask : send

  task automatic wr(input logic [7:0] a, input int n, input logic [23:0] d);
    rgbpwm_host_i.start_c();
    send({CHIP_ADDR, 1'b0});
    send(a);
    for (int i = n - 1; i >= 0; i--) send(d[8*i +: 8]);
    rgbpwm_host_i.stop_c();
  endtask : wr

  // pointer set by an empty write, then one byte read and nacked
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    wr(a, 0, 24'h0);
    rgbpwm_host_i.start_c();
    send({CHIP_ADDR, 1'b1});
    rgbpwm_host_i.get(1'b1, v);
    rgbpwm_host_i.stop_c();
    check({8'h0, v}, {8'h0, exp});
  endtask : rd_chk

  // one frame reads two bytes; the host acks the first to go on
  task automatic rd2_chk(input logic [7:0] a, input logic [7:0] e0,
                         input logic [7:0] e1);
    logic [7:0] v0, v1;
    wr(a, 0, 24'h0);
    rgbpwm_host_i.start_c();
    send({CHIP_ADDR, 1'b1});
    rgbpwm_host_i.get(1'b0, v0);
    rgbpwm_host_i.get(1'b1, v1);
    rgbpwm_host_i.stop_c();
    check({8'h0, v0}, {8'h0, e0});
    check({8'h0, v1}, {8'h0, e1});
  endtask : rd2_chk

  // a foreign chip address is not acked and the whole frame is ignored
  task automatic t_bad_chip();
    logic ack;
    rgbpwm_host_i.start_c();
    rgbpwm_host_i.put({CHIP_ADDR + 7'h01, 1'b0}, ack);
    check({15'h0, ack}, 16'h0);
    rgbpwm_host_i.put(ADDR_GREEN, ack);
    check({15'h0, ack}, 16'h0);
    rgbpwm_host_i.put(8'h77, ack);
    rgbpwm_host_i.stop_c();
    check({15'h0, ack}, 16'h0);
    rd_chk(ADDR_GREEN, 8'h22);
  endtask : t_bad_chip

  task automatic pwm_chk(input int n, input int er, input int eg,
                         input int eb);
    logic [15:0] r, g, b;
    r = 16'h0;
    g = 16'h0;
    b = 16'h0;
    // sample mid-cycle where the sinks are settled, then realign
    repeat (n) begin
      @(negedge core_clk);
      r = r + {15'h0, red};
      g = g + {15'h0, green};
      b = b + {15'h0, blue};
    end
    @(posedge core_clk);
    check(r, er[15:0]);
    check(g, eg[15:0]);
    check(b, eb[15:0]);
  endtask : pwm_chk

  task automatic t_power_on();
    pwm_chk(64, 0, 0, 0);
    rd_chk(ADDR_RED, 8'h00);
    rd_chk(ADDR_BLUE, 8'h00);
    rd_chk(ADDR_REFRESH, 8'hF3);
  endtask : t_power_on

  task automatic t_seq_write();
    wr(ADDR_RED, 3, 24'h112233);
    rd_chk(ADDR_RED, 8'h11);
    rd_chk(ADDR_GREEN, 8'h22);
    rd_chk(ADDR_BLUE, 8'h33);
    rd2_chk(ADDR_RED, 8'h11, 8'h22);
    wr(ADDR_BLUE, 2, 24'h0033AA);
    rd_chk(ADDR_BLUE + 8'h01, 8'h00);
    wr(ADDR_REFRESH, 1, 24'h0);
    rd_chk(ADDR_REFRESH, 8'h00);
    rd_chk(ADDR_BLUE, 8'h33);
  endtask : t_seq_write

  // steps of one 256th; zero never on, full always on
  task automatic t_duty_levels();
    logic [7:0] lv [4];
    int         e;
    lv = '{8'h00, 8'h01, 8'h80, 8'hFF};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_RED, 3, {lv[i], lv[i], lv[i]});
      e = (lv[i] == 8'hFF) ? 512 : 2 * lv[i];
      pwm_chk(512, e, e, e);
    end
  endtask : t_duty_levels

  task automatic t_channels();
    wr(ADDR_RED, 3, 24'h8000FF);
    pwm_chk(512, 256, 0, 512);
  endtask : t_channels

  // refresh 1 doubles every step, so the period grows to 1024
  task automatic t_refresh();
    wr(ADDR_REFRESH, 1, 24'h01);
    wr(ADDR_RED, 1, 24'h40);
    pwm_chk(1024, 256, 0, 1024);
  endtask : t_refresh

  task automatic t_volatile();
    wr(ADDR_GREEN, 1, 24'h55);
    do_reset();
    pwm_chk(64, 0, 0, 0);
    rd_chk(ADDR_GREEN, 8'h00);
    rd_chk(ADDR_REFRESH, 8'hF3);
  endtask : t_volatile

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // runs take about 16k cycles; 90k means a hang
  initial begin
    #900000;
    fails++;
    complete_run();
  end

  initial begin
    fails = 0;
    tests_run = 0;
    rst_n = 1'b0;
    do_reset();
    t_power_on();
    t_seq_write();
    t_bad_chip();
    t_duty_levels();
    t_channels();
    t_refresh();
    t_volatile();
    complete_run();
  end
endmodule : test_rgbpwm_top
`default_nettype wire
